// file: verilog/pskc_pkg.sv
package pskc_pkg;

  // Sample and register widths.
  localparam int unsigned SAMPLE_W      = 24;
  localparam int unsigned SKEW_W        = 10;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned ADDR_W        = 16;

  // Word addresses on the parallel register port.
  localparam logic [15:0] ADDR_PHASE_A_SKEW = 16'h0001;
  localparam logic [15:0] ADDR_PHASE_B_SKEW = 16'h0002;
  localparam logic [15:0] ADDR_PHASE_C_SKEW = 16'h0003;
  localparam logic [15:0] ADDR_REF_CONFIG   = 16'h0004;

  // Field positions and reset values.
  localparam int unsigned SKEW_DIR_BIT      = 9;
  localparam int unsigned EXT_REF_SEL_BIT   = 0;
  localparam logic [9:0]  SKEW_RESET        = 10'h000;
  localparam logic [0:0]  EXT_REF_RESET     = 1'h0;

  // Correction limits in steps.
  localparam logic [8:0]  MAX_ADVANCE_STEPS = 9'h17f;
  localparam logic [8:0]  MAX_DELAY_STEPS   = 9'h03f;
  localparam int unsigned LINE_DEPTH        = 447;

  // Step clock: 1.024 MHz derived from the 10 MHz core clock.
  localparam int unsigned CORE_CLK_KHZ      = 10000;
  localparam int unsigned STEP_CLK_KHZ      = 1024;
  localparam int unsigned STEP_PERIOD_PS    = 976;
  localparam logic [13:0] STEP_ACC_INC      = 14'(STEP_CLK_KHZ);
  localparam logic [13:0] STEP_ACC_MOD      = 14'(CORE_CLK_KHZ);

  // Power modes.
  localparam logic [1:0]  MODE_NORMAL       = 2'h0;

endpackage : pskc_pkg

// file: verilog/pskc_delay_line.sv
`timescale 1ns/1ps
module pskc_delay_line
  import pskc_pkg::*;
#(
  parameter int unsigned WIDTH = SAMPLE_W,
  parameter int unsigned DEPTH = LINE_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             step_en,
  input  wire logic [WIDTH-1:0] din,
  input  wire logic [9:0]       tap,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [9:0]                  wptr;
    logic [WIDTH-1:0]            dout;
  } pskc_line_t;

  pskc_line_t line_reg;
  pskc_line_t line_next;

  // Output is the sample written tap steps earlier; a tap of zero passes through.
  always_comb begin
    logic [9:0] rd_idx;
    rd_idx    = '0;
    line_next = line_reg;
    if (step_en) begin
      rd_idx = (line_reg.wptr >= tap) ? line_reg.wptr - tap
                                      : 10'(line_reg.wptr + 10'(DEPTH) - tap);
      line_next.dout = (tap == 10'h000) ? din : line_reg.mem[rd_idx];
      line_next.mem[line_reg.wptr] = din;
      line_next.wptr = (line_reg.wptr == 10'(DEPTH - 1)) ? 10'h000 : line_reg.wptr + 10'h001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_reg <= '0;
    end else begin
      line_reg <= line_next;
    end
  end

  assign dout = line_reg.dout;

endmodule : pskc_delay_line

// file: verilog/pskc_top.sv
`timescale 1ns/1ps
module pskc_top
  import pskc_pkg::*;
#(
  parameter int unsigned SAMPLE_WIDTH = SAMPLE_W
) (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  input  wire logic                    sw_reset,
  input  wire logic [1:0]              power_mode,
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_rd_en,
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [WORD_W-1:0]       reg_wdata,
  output logic      [WORD_W-1:0]       reg_rdata,
  output logic                         reg_rd_valid,
  output logic                         step_tick,
  input  wire logic [SAMPLE_WIDTH-1:0] v_sample_a,
  input  wire logic [SAMPLE_WIDTH-1:0] v_sample_b,
  input  wire logic [SAMPLE_WIDTH-1:0] v_sample_c,
  input  wire logic [SAMPLE_WIDTH-1:0] i_sample_a,
  input  wire logic [SAMPLE_WIDTH-1:0] i_sample_b,
  input  wire logic [SAMPLE_WIDTH-1:0] i_sample_c,
  output logic      [SAMPLE_WIDTH-1:0] v_out_a,
  output logic      [SAMPLE_WIDTH-1:0] v_out_b,
  output logic      [SAMPLE_WIDTH-1:0] v_out_c,
  output logic      [SAMPLE_WIDTH-1:0] i_out_a,
  output logic      [SAMPLE_WIDTH-1:0] i_out_b,
  output logic      [SAMPLE_WIDTH-1:0] i_out_c,
  output logic                         external_ref_select
);

  typedef struct packed {
    logic [2:0][SKEW_W-1:0] skew_cal;
    logic                   ext_ref;
    logic [13:0]            step_acc;
    logic                   step_tick;
    logic [WORD_W-1:0]      rdata;
    logic                   rd_valid;
  } pskc_state_t;

  pskc_state_t state_reg;
  pskc_state_t state_next;

  // Turns a stored skew code into the voltage tap, centred on the fixed current tap.
  function automatic logic [9:0] pskc_voltage_tap(input logic [SKEW_W-1:0] code);
    logic [8:0] mag;
    mag = code[8:0];
    if (code[SKEW_DIR_BIT]) begin
      if (mag > MAX_DELAY_STEPS) mag = MAX_DELAY_STEPS;
      return 10'(MAX_ADVANCE_STEPS) + 10'(mag);
    end else begin
      if (mag > MAX_ADVANCE_STEPS) mag = MAX_ADVANCE_STEPS;
      return 10'(MAX_ADVANCE_STEPS - mag);
    end
  endfunction : pskc_voltage_tap

  // Maps a register address to a skew register index, or 3 when none.
  function automatic logic [1:0] pskc_skew_index(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_PHASE_A_SKEW: return 2'h0;
      ADDR_PHASE_B_SKEW: return 2'h1;
      ADDR_PHASE_C_SKEW: return 2'h2;
      default:           return 2'h3;
    endcase
  endfunction : pskc_skew_index

  always_comb begin
    logic [1:0]  idx;
    logic [13:0] acc_sum;
    state_next = state_reg;
    idx        = pskc_skew_index(reg_addr);
    acc_sum    = state_reg.step_acc + STEP_ACC_INC;
    // Fractional divider: 1024 ticks in every 10000 core cycles.
    if (acc_sum >= STEP_ACC_MOD) begin
      state_next.step_acc  = acc_sum - STEP_ACC_MOD;
      state_next.step_tick = 1'b1;
    end else begin
      state_next.step_acc  = acc_sum;
      state_next.step_tick = 1'b0;
    end
    state_next.rd_valid = reg_rd_en;
    state_next.rdata    = '0;
    if (reg_rd_en) begin
      if (idx != 2'h3) begin
        state_next.rdata = {6'h00, state_reg.skew_cal[idx]};
      end else if (reg_addr == ADDR_REF_CONFIG) begin
        state_next.rdata[EXT_REF_SEL_BIT] = state_reg.ext_ref;
      end
    end
    if (reg_wr_en) begin
      if (idx != 2'h3) begin
        state_next.skew_cal[idx] = reg_wdata[SKEW_W-1:0];
      end else if (reg_addr == ADDR_REF_CONFIG) begin
        state_next.ext_ref = reg_wdata[EXT_REF_SEL_BIT];
      end
    end
    // Power mode changes leave the configuration untouched.
    if (sw_reset) begin
      state_next.skew_cal = {3{SKEW_RESET}};
      state_next.ext_ref  = EXT_REF_RESET[0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  logic [2:0][SAMPLE_WIDTH-1:0] v_in;
  logic [2:0][SAMPLE_WIDTH-1:0] i_in;
  logic [2:0][SAMPLE_WIDTH-1:0] v_out;
  logic [2:0][SAMPLE_WIDTH-1:0] i_out;

  assign v_in = {v_sample_c, v_sample_b, v_sample_a};
  assign i_in = {i_sample_c, i_sample_b, i_sample_a};

  for (genvar p = 0; p < 3; p++) begin : g_phase
    // Voltage tap follows the phase's own skew code.
    pskc_delay_line #(.WIDTH(SAMPLE_WIDTH), .DEPTH(LINE_DEPTH)) u_v_line (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .step_en  (state_reg.step_tick),
      .din      (v_in[p]),
      .tap      (pskc_voltage_tap(state_reg.skew_cal[p])),
      .dout     (v_out[p])
    );
    // Current is held at the centre latency so the voltage can move either way.
    pskc_delay_line #(.WIDTH(SAMPLE_WIDTH), .DEPTH(LINE_DEPTH)) u_i_line (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .step_en  (state_reg.step_tick),
      .din      (i_in[p]),
      .tap      (10'(MAX_ADVANCE_STEPS)),
      .dout     (i_out[p])
    );
  end

  assign v_out_a             = v_out[0];
  assign v_out_b             = v_out[1];
  assign v_out_c             = v_out[2];
  assign i_out_a             = i_out[0];
  assign i_out_b             = i_out[1];
  assign i_out_c             = i_out[2];
  assign reg_rdata           = state_reg.rdata;
  assign reg_rd_valid        = state_reg.rd_valid;
  assign step_tick           = state_reg.step_tick;
  assign external_ref_select = state_reg.ext_ref;

endmodule : pskc_top

// file: verification/pskc_props.sv
`timescale 1ns/1ps
module pskc_props
  import pskc_pkg::*;
#(
  parameter int unsigned SAMPLE_WIDTH = SAMPLE_W
) (
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  input wire logic                    sw_reset,
  input wire logic                    reg_wr_en,
  input wire logic                    reg_rd_en,
  input wire logic [ADDR_W-1:0]       reg_addr,
  input wire logic [WORD_W-1:0]       reg_wdata,
  input wire logic [WORD_W-1:0]       reg_rdata,
  input wire logic                    reg_rd_valid,
  input wire logic                    step_tick,
  input wire logic [SAMPLE_WIDTH-1:0] v_out_a,
  input wire logic                    external_ref_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire ref_wr = reg_wr_en && reg_addr == ADDR_REF_CONFIG && !sw_reset;
  AST_RD_ANSWER: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read got no answer");
  AST_RD_QUIET: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("answer without read");
  AST_PAD: assert property (reg_rd_valid |-> reg_rdata[15:10] == 6'h00)
    else $error("upper bits not zero");
  AST_REF_SET: assert property (ref_wr |=> external_ref_select == $past(reg_wdata[0]))
    else $error("reference select not written");
  AST_SW_CLEAR: assert property (sw_reset |=> !external_ref_select)
    else $error("reference select not cleared");
  AST_REF_KEEP: assert property (!ref_wr && !sw_reset |=> $stable(external_ref_select))
    else $error("reference select changed");
  AST_STEP_RATE: assert property (step_tick |=> !step_tick [*8] ##[1:2] step_tick)
    else $error("step spacing wrong");
  AST_HOLD: assert property (!step_tick |=> $stable(v_out_a))
    else $error("output moved between steps");
  cover property (ref_wr ##1 external_ref_select);
  cover property (reg_rd_valid && reg_rdata != 16'h0000);
  cover property (step_tick ##1 v_out_a != 24'h000000);
endmodule : pskc_props

bind pskc_top pskc_props #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) u_props (.core_clk, .arst_n,
  .sw_reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
  .step_tick, .v_out_a, .external_ref_select);

// file: verification/pskc_tb.sv
`timescale 1ns/1ps
module testbench
  import pskc_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        sw_reset = 1'b0;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [1:0]  power_mode = 2'h0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [23:0] smp = 24'h000000;
  wire  [15:0] reg_rdata;
  wire         reg_rd_valid;
  wire         step_tick;
  wire         external_ref_select;
  wire  [23:0] o [6];
  int          errors = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #50 core_clk = ~core_clk;

  pskc_top dut (.core_clk, .arst_n, .sw_reset, .power_mode, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .step_tick, .v_sample_a(smp),
    .v_sample_b(smp), .v_sample_c(smp), .i_sample_a(smp), .i_sample_b(smp),
    .i_sample_c(smp), .v_out_a(o[0]), .v_out_b(o[1]), .v_out_c(o[2]), .i_out_a(o[3]),
    .i_out_b(o[4]), .i_out_c(o[5]), .external_ref_select);

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic tick1();
    @(posedge core_clk);
    #1;
  endtask : tick1

  // Returns just after the edge that took a sample.
  task automatic next_tick();
    do tick1(); while (step_tick !== 1'b1);
    tick1();
  endtask : next_tick

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    tick1();
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick1();
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    tick1();
    reg_rd_en = 1'b1;
    reg_addr = a;
    tick1();
    reg_rd_en = 1'b0;
    chk(24'(reg_rd_valid), 24'h000001, "read answer");
    chk(24'(reg_rdata), 24'(exp), "read data");
  endtask : rd

  task automatic t_regs();
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_PHASE_A_SKEW + 16'(k), 16'hfc00 | 16'(k * 7 + 1));
    end
    for (int k = 0; k < 3; k++) begin
      rd(ADDR_PHASE_A_SKEW + 16'(k), 16'(k * 7 + 1));
    end
    wr(ADDR_PHASE_B_SKEW, 16'hfe3f);
    rd(ADDR_PHASE_B_SKEW, 16'h023f);
    rd(16'h0007, 16'h0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_ref();
    rd(ADDR_REF_CONFIG, 16'h0000);
    wr(ADDR_REF_CONFIG, 16'h0001);
    for (int m = 1; m < 4; m++) begin
      power_mode = 2'(m);
      tick1();
      chk(24'(external_ref_select), 24'h000001, "ref kept");
    end
    power_mode = MODE_NORMAL;
    rd(ADDR_REF_CONFIG, 16'h0001);
    sw_reset = 1'b1;
    tick1();
    sw_reset = 1'b0;
    chk(24'(external_ref_select), 24'h000000, "ref cleared");
    $display("test ref done");
  endtask : t_ref

  task automatic t_path();
    int seen [6];
    int exp_n [6] = '{0, 446, 378, 383, 383, 383};
    wr(ADDR_PHASE_A_SKEW, 16'h017f);
    wr(ADDR_PHASE_B_SKEW, 16'h023f);
    wr(ADDR_PHASE_C_SKEW, 16'h0005);
    seen = '{default: -1};
    // Let a step pass first, so that exactly one step takes the marked sample.
    next_tick();
    smp = 24'h5a5a5a;
    for (int n = 0; n < 450; n++) begin
      next_tick();
      smp = 24'h000000;
      for (int j = 0; j < 6; j++) begin
        if (o[j] === 24'h5a5a5a && seen[j] < 0) seen[j] = n;
      end
    end
    for (int j = 0; j < 6; j++) begin
      chk(24'(seen[j]), 24'(exp_n[j]), "sample shift");
    end
    $display("test path done");
  endtask : t_path

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    t_regs();
    t_ref();
    t_path();
    finish_test();
  end
endmodule : testbench
